// >>> verilog/vsc_map.vh
// Subaddress map, field positions, reset values and codes of the slicer register bank
`ifndef VSC_MAP_VH
`define VSC_MAP_VH
`define VSC_ADDR_LINE_FIRST   8'h41
`define VSC_ADDR_LINE_LAST    8'h57
`define VSC_ADDR_PATTERN      8'h58
`define VSC_ADDR_HPOS_LOW     8'h59
`define VSC_ADDR_VPOS_LOW     8'h5A
`define VSC_ADDR_OFFSET_MSBS  8'h5B
`define VSC_ADDR_ANC_ID       8'h5D
`define VSC_ADDR_SEC_ID       8'h5E
`define VSC_ADDR_DETECT       8'h60
`define VSC_ADDR_FIELD_LINE   8'h61
`define VSC_ADDR_LINE_TYPE    8'h62
`define VSC_LINE_FIRST_NUM    9'h002
`define VSC_LINE_COUNT_REGS   23
`define VSC_RST_LINE_TYPE     8'hFF
`define VSC_RST_PATTERN       8'h40
`define VSC_RST_HPOS_LOW      8'h00
`define VSC_RST_VPOS_LOW      8'h00
`define VSC_RST_OFFSET_MSBS   8'h00
`define VSC_RST_ANC_ID        8'h00
`define VSC_RST_SEC_ID        8'h00
`define VSC_BIT_FIELD_INVERT  7
`define VSC_BIT_RECODE        6
`define VSC_BIT_VPOS_TOP      4
`define VSC_BIT_FV_SOURCE     7
`define VSC_VPOS_MAX          9'd312
`define VSC_DT_WSS            4'h3
`define VSC_DT_CC525          4'h5
`define VSC_DT_TEST_LINE      4'h6
`define VSC_DT_VITC625        4'h9
`define VSC_DT_VITC525        4'hA
`define VSC_DT_JFS            4'hE
`define VSC_DT_ACTIVE         4'hF
`define VSC_WSS_PATTERN       24'h1E3C1F
`define VSC_CC_PATTERN        3'h1
`define VSC_DID_SAV_FV_SET    6'h3E
`define VSC_DID_SAV_FV_CLR    6'h3F
`define VSC_BYTE_ZERO         8'h00
`define VSC_BYTE_ONES         8'hFF
`define VSC_BYTE_ZERO_RECODE  8'h03
`define VSC_BYTE_ONES_RECODE  8'hFC
`define VSC_FRAME_ANC         2'h0
`define VSC_FRAME_SAV_FV_SET  2'h1
`define VSC_FRAME_SAV_FV_CLR  2'h2
`define VSC_MODE_VIDEO        3'h0
`define VSC_MODE_FIXED        3'h1
`define VSC_MODE_PROG         3'h2
`define VSC_MODE_CC           3'h3
`define VSC_MODE_RAW          3'h4
`endif

// >>> verilog/vsc_slicer_regs.v
// Configuration and status register bank of the VBI data slicer
// Contract
// - One line-type byte per line 2..24; high nibble field 1, low nibble field 2.
// - Type 0011 is widescreen signalling, hunting the three-byte framing pattern.
// - Type 0101 is US closed caption using the three-bit start pattern.
// - Type 0110 passes the VBI video component unsliced, no pattern search.
// - Type 1111, the default, is active video: video component output.
// - Types 1001 and 1010 take the programmable framing pattern.
// - Type 1110 selects Japanese format switch with programmable framing pattern.
// - Programmable framing pattern is eight bits, reset value 40H.
// - Horizontal offset is eleven bits: three high bits shared, low byte alone.
// - Vertical offset is nine bits, top bit shared, legal range 0 to 312.
// - Field-invert bit set inverts the slicer field indicator, clear leaves it.
// - Recode bit set maps bytes 00H to 03H and FFH to FCH.
// - Source bit clear: field and blank follow table; set: decoder real-time signals.
// - Identification zero, the default, frames sliced output with ancillary headers.
// - Identification 3EH or 3FH selects SAV/EAV framing for source set or clear.
// - A six-bit secondary identification, reset zero, goes into ancillary headers.
// - Status bit 6 flags exact pattern match, bit 5 a one-error match.
// - Status bits 4, 3, 2 flag program service, widescreen, caption seen.
// - First line-status byte bit 5 shows slicer field identity, zero in field 1.
// - Nine-bit line count split over two status bytes, data type in low nibble.
`timescale 1ns/10ps
`include "vsc_map.vh"

module vsc_slicer_regs (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [7:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  output reg  [7:0]  reg_rdata,
  input  wire [8:0]  line_count,
  input  wire        frame_start,
  input  wire        field_raw,
  input  wire        decoder_even_field,
  input  wire        decoder_vert_blank,
  input  wire        ev_pattern_exact,
  input  wire        ev_pattern_one_err,
  input  wire        ev_prog_service,
  input  wire        ev_widescreen,
  input  wire        ev_caption,
  input  wire [7:0]  slice_byte_in,
  output reg  [7:0]  slice_byte_out,
  output wire [3:0]  line_data_type,
  output reg  [2:0]  slice_mode,
  output reg  [23:0] frame_pattern,
  output reg  [4:0]  frame_pattern_len,
  output wire        pattern_search_en,
  output wire [10:0] slice_hpos,
  output wire [8:0]  slice_vpos,
  output wire        slicer_field_id,
  output wire        slicer_field_out,
  output wire        slicer_vblank_out,
  output reg  [1:0]  frame_style,
  output wire [5:0]  anc_data_id,
  output wire [5:0]  anc_secondary_id
);

  reg  [7:0] line_type_sel [0:22];
  reg  [7:0] prog_frame_pattern;
  reg  [7:0] slice_hpos_low;
  reg  [7:0] slice_vpos_low;
  reg  [7:0] field_recode_offset_msbs;
  reg  [7:0] anc_header_id_ctrl;
  reg  [7:0] sliced_secondary_id;
  reg  [4:0] seen_acc;
  reg  [4:0] seen_last;
  reg        in_table;
  reg  [4:0] line_idx;
  reg  [8:0] line_rel;
  reg  [7:0] line_entry;
  wire [4:0] seen_ev;
  wire       field_invert;
  wire       field_vblank_source;
  wire       recode_en;
  wire       slice_vpos_top_bit;

  assign field_invert        = field_recode_offset_msbs[`VSC_BIT_FIELD_INVERT];
  assign recode_en           = field_recode_offset_msbs[`VSC_BIT_RECODE];
  assign slice_vpos_top_bit  = field_recode_offset_msbs[`VSC_BIT_VPOS_TOP];
  assign field_vblank_source = anc_header_id_ctrl[`VSC_BIT_FV_SOURCE];

  // Line-type table, one byte per line from 2 to 24, at reset all active video
  genvar gi;
  generate
    for (gi = 0; gi < `VSC_LINE_COUNT_REGS; gi = gi + 1) begin : g_line
      // Subaddress of this line; a genvar cannot be part-selected, so size it here
      localparam [7:0] LINE_ADDR = `VSC_ADDR_LINE_FIRST + gi;
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          line_type_sel[gi] <= `VSC_RST_LINE_TYPE;
        end else if (reg_wr && (reg_addr == LINE_ADDR)) begin
          line_type_sel[gi] <= reg_wdata;
        end
      end
    end
  endgenerate

  // Writable control registers; status subaddresses are not decoded here
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prog_frame_pattern       <= `VSC_RST_PATTERN;
      slice_hpos_low           <= `VSC_RST_HPOS_LOW;
      slice_vpos_low           <= `VSC_RST_VPOS_LOW;
      field_recode_offset_msbs <= `VSC_RST_OFFSET_MSBS;
      anc_header_id_ctrl       <= `VSC_RST_ANC_ID;
      sliced_secondary_id      <= `VSC_RST_SEC_ID;
    end else if (reg_wr) begin
      case (reg_addr)
        `VSC_ADDR_PATTERN:     prog_frame_pattern <= reg_wdata;
        `VSC_ADDR_HPOS_LOW:    slice_hpos_low <= reg_wdata;
        `VSC_ADDR_VPOS_LOW:    slice_vpos_low <= reg_wdata;
        `VSC_ADDR_OFFSET_MSBS: field_recode_offset_msbs <= reg_wdata & 8'hD7;
        `VSC_ADDR_ANC_ID:      anc_header_id_ctrl <= reg_wdata & 8'hBF;
        `VSC_ADDR_SEC_ID:      sliced_secondary_id <= reg_wdata & 8'h3F;
        default: begin
        end
      endcase
    end
  end

  // Offsets assembled from shared high bits; range is software's to respect
  assign slice_hpos = {field_recode_offset_msbs[2:0], slice_hpos_low};
  assign slice_vpos = {slice_vpos_top_bit, slice_vpos_low};
  assign anc_data_id      = anc_header_id_ctrl[5:0];
  assign anc_secondary_id = sliced_secondary_id[5:0];

  // Field indicator, optionally inverted for 525-line sources
  assign slicer_field_id = field_raw ^ field_invert;

  // Table lookup for the current line; outside 2..24 treat as active video
  always @* begin
    line_rel   = line_count - `VSC_LINE_FIRST_NUM;
    in_table   = (line_count >= `VSC_LINE_FIRST_NUM) &&
                 (line_rel < `VSC_LINE_COUNT_REGS);
    line_idx   = line_rel[4:0];
    line_entry = in_table ? line_type_sel[line_idx] : `VSC_RST_LINE_TYPE;
  end

  // Field 1 uses the high nibble, field 2 the low nibble
  assign line_data_type = slicer_field_id ? line_entry[3:0] : line_entry[7:4];

  // Data-type decode into slicing mode and framing pattern
  always @* begin
    slice_mode        = `VSC_MODE_FIXED;
    frame_pattern     = 24'h000000;
    frame_pattern_len = 5'd0;
    case (line_data_type)
      `VSC_DT_WSS: begin
        frame_pattern     = `VSC_WSS_PATTERN;
        frame_pattern_len = 5'd24;
      end
      `VSC_DT_CC525: begin
        slice_mode        = `VSC_MODE_CC;
        frame_pattern     = {21'h000000, `VSC_CC_PATTERN};
        frame_pattern_len = 5'd3;
      end
      `VSC_DT_TEST_LINE: begin
        slice_mode = `VSC_MODE_RAW;
      end
      `VSC_DT_VITC625, `VSC_DT_VITC525: begin
        slice_mode        = `VSC_MODE_PROG;
        frame_pattern     = {16'h0000, prog_frame_pattern};
        frame_pattern_len = 5'd8;
      end
      `VSC_DT_JFS: begin
        slice_mode        = `VSC_MODE_PROG;
        frame_pattern     = {16'h0000, prog_frame_pattern};
        frame_pattern_len = 5'd8;
      end
      `VSC_DT_ACTIVE: begin
        slice_mode = `VSC_MODE_VIDEO;
      end
      default: begin
        slice_mode = `VSC_MODE_FIXED;
      end
    endcase
  end

  // No pattern hunt on unsliced lines
  assign pattern_search_en = (frame_pattern_len != 5'd0);

  // Field and blank source: table-driven or decoder real-time
  assign slicer_field_out  = field_vblank_source ? decoder_even_field : slicer_field_id;
  assign slicer_vblank_out = field_vblank_source ? decoder_vert_blank :
                             (slice_mode != `VSC_MODE_VIDEO);

  // Framing style from the identification code
  always @* begin
    case (anc_header_id_ctrl[5:0])
      `VSC_DID_SAV_FV_SET: frame_style = `VSC_FRAME_SAV_FV_SET;
      `VSC_DID_SAV_FV_CLR: frame_style = `VSC_FRAME_SAV_FV_CLR;
      default:             frame_style = `VSC_FRAME_ANC;
    endcase
  end

  // Byte recode keeps sliced data clear of timing-reference codes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slice_byte_out <= 8'h00;
    end else if (recode_en && (slice_byte_in == `VSC_BYTE_ZERO)) begin
      slice_byte_out <= `VSC_BYTE_ZERO_RECODE;
    end else if (recode_en && (slice_byte_in == `VSC_BYTE_ONES)) begin
      slice_byte_out <= `VSC_BYTE_ONES_RECODE;
    end else begin
      slice_byte_out <= slice_byte_in;
    end
  end

  assign seen_ev = {ev_pattern_exact, ev_pattern_one_err, ev_prog_service,
                    ev_widescreen, ev_caption};

  // Detection gathered over a frame, published at frame start; an event in
  // the boundary cycle lands in the published set so it is not lost
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      seen_acc  <= 5'h00;
      seen_last <= 5'h00;
    end else if (frame_start) begin
      seen_last <= seen_acc | seen_ev;
      seen_acc  <= 5'h00;
    end else begin
      seen_acc  <= seen_acc | seen_ev;
    end
  end

  // Read mux, registered; status reads only, writes there fall to default
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      if ((reg_addr >= `VSC_ADDR_LINE_FIRST) && (reg_addr <= `VSC_ADDR_LINE_LAST)) begin
        reg_rdata <= line_type_sel[reg_addr[4:0] - 5'd1];
      end else begin
        case (reg_addr)
          `VSC_ADDR_PATTERN:     reg_rdata <= prog_frame_pattern;
          `VSC_ADDR_HPOS_LOW:    reg_rdata <= slice_hpos_low;
          `VSC_ADDR_VPOS_LOW:    reg_rdata <= slice_vpos_low;
          `VSC_ADDR_OFFSET_MSBS: reg_rdata <= field_recode_offset_msbs;
          `VSC_ADDR_ANC_ID:      reg_rdata <= anc_header_id_ctrl;
          `VSC_ADDR_SEC_ID:      reg_rdata <= sliced_secondary_id;
          `VSC_ADDR_DETECT:      reg_rdata <= {1'b0, seen_last, 2'b00};
          `VSC_ADDR_FIELD_LINE:  reg_rdata <= {2'b00, slicer_field_id, line_count[8:4]};
          `VSC_ADDR_LINE_TYPE:   reg_rdata <= {line_count[3:0], line_data_type};
          default:               reg_rdata <= 8'h00;
        endcase
      end
    end
  end

endmodule // vsc_slicer_regs

// >>> testbench/vsc_slicer_regs_chk.sv
// Concurrent checks on the slicer register bank ports
`timescale 1ns/10ps
module vsc_slicer_chk (
  input wire ref_clk, input wire rst, input wire reg_wr, input wire reg_rd,
  input wire [7:0] reg_addr, input wire [7:0] reg_wdata, input wire [7:0] reg_rdata,
  input wire frame_start, input wire ev_caption, input wire field_raw,
  input wire [7:0] slice_byte_in, input wire [7:0] slice_byte_out,
  input wire [3:0] line_data_type, input wire [2:0] slice_mode,
  input wire [23:0] frame_pattern, input wire [4:0] frame_pattern_len,
  input wire pattern_search_en, input wire slicer_field_id, input wire [1:0] frame_style
);
  reg [7:0] fc;
  reg [5:0] dd;
  reg       fi;
  reg       rc;
  // Shadow of the control bits that the outputs depend on
  always @(posedge ref_clk or posedge rst)
    if (rst) {fc, fi, rc, dd} <= {8'h40, 2'b00, 6'h00};
    else if (reg_wr && reg_addr == 8'h58) fc <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h5B) {fi, rc} <= reg_wdata[7:6];
    else if (reg_wr && reg_addr == 8'h5D) dd <= reg_wdata[5:0];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // Caption published at frame start, status read two cycles later
  sequence s_pub;
    frame_start && ev_caption;
  endsequence
  sequence s_rd;
    !frame_start ##1 reg_rd && reg_addr == 8'h60 && !frame_start;
  endsequence
  a_wss_pattern: assert property (line_data_type == 4'h3 |->
    frame_pattern == 24'h1E3C1F && frame_pattern_len == 5'd24) else $error("wss pattern");
  a_cc_pattern: assert property (line_data_type == 4'h5 |->
    slice_mode == 3'h3 && frame_pattern == 24'h000001 && frame_pattern_len == 5'd3)
    else $error("caption pattern");
  a_raw_unsliced: assert property (line_data_type == 4'h6 |->
    slice_mode == 3'h4 && !pattern_search_en) else $error("raw line searched");
  a_video_out: assert property (line_data_type == 4'hF |->
    slice_mode == 3'h0 && !pattern_search_en) else $error("active video sliced");
  a_prog_pattern: assert property (line_data_type inside {4'h9, 4'hA, 4'hE} |->
    frame_pattern == {16'h0000, fc} && frame_pattern_len == 5'd8) else $error("prog pattern");
  a_field_invert: assert property (slicer_field_id == (field_raw ^ fi))
    else $error("field indicator");
  // Xor with 03 maps 00 to 03 and FF to FC
  a_recode_map: assert property (rc && slice_byte_in inside {8'h00, 8'hFF} |=>
    slice_byte_out == ($past(slice_byte_in) ^ 8'h03)) else $error("recode");
  a_plain_pass: assert property (!rc |=> slice_byte_out == $past(slice_byte_in))
    else $error("byte altered");
  a_sav_style: assert property (dd inside {6'h3E, 6'h3F} |->
    frame_style == (dd == 6'h3E ? 2'h1 : 2'h2)) else $error("sav framing");
  a_anc_style: assert property (dd == 6'h00 |-> frame_style == 2'h0)
    else $error("anc framing");
  a_caption_flag: assert property (s_pub ##1 s_rd |=> reg_rdata[2])
    else $error("caption flag");
endmodule // vsc_slicer_chk
bind vsc_slicer_regs vsc_slicer_chk vsc_slicer_chk_i (.*);

// >>> testbench/vsc_host_model.sv
// Host model issuing subaddressed register writes and reads
`timescale 1ns/10ps
module vsc_host_model (
  input  wire        ref_clk,
  output logic       reg_wr,
  output logic       reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input  wire  [7:0] reg_rdata
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Strobe rises after one falling edge and drops after the next
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      reg_wdata = ~d; // Released data must not look like the last value
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    begin
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      d = reg_rdata; // Landed on the edge that took the strobe
    end
  endtask
endmodule // vsc_host_model

// >>> testbench/vsc_slicer_regs_tb.sv
// Self-checking bench for the slicer register bank
`timescale 1ns/10ps
module vsc_slicer_regs_tb;
  logic ref_clk = 1'b0, rst = 1'b1, field_raw = 1'b0, decoder_even_field = 1'b0;
  logic decoder_vert_blank = 1'b0, frame_start, ev_pattern_exact, ev_pattern_one_err;
  logic ev_prog_service, ev_widescreen, ev_caption, reg_wr, reg_rd, pattern_search_en;
  logic slicer_field_id, slicer_field_out, slicer_vblank_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, slice_byte_out, v, slice_byte_in = 8'h00;
  logic [8:0] slice_vpos, line_count = 9'h000;
  logic [23:0] frame_pattern;
  logic [10:0] slice_hpos;
  logic [5:0] anc_data_id, anc_secondary_id, evs = 6'h00;
  logic [4:0] frame_pattern_len;
  logic [3:0] line_data_type;
  logic [2:0] slice_mode;
  logic [1:0] frame_style;
  int errors = 0, checks = 0, cycles = 0;
  assign {frame_start, ev_pattern_exact, ev_pattern_one_err} = evs[5:3];
  assign {ev_prog_service, ev_widescreen, ev_caption} = evs[2:0];
  vsc_slicer_regs vsc_slicer_regs_i (.*);
  vsc_host_model vsc_host_model_i (.*);
  always #12.5 ref_clk = ~ref_clk;
  // A hang counts as a mismatch
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      complete_run;
    end
  end
  task complete_run;
    begin
      if (errors == 0 && checks > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask
  task chk(input [23:0] got, input [23:0] exp);
    begin
      checks++;
      if (got !== exp) begin
        errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    vsc_host_model_i.wr(a, d);
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    begin
      vsc_host_model_i.rd(a, v);
      chk(v, e);
    end
  endtask
  // Events for one cycle; bit 5 is the frame start
  task pulse(input [5:0] e);
    begin
      @(negedge ref_clk);
      evs = e;
      @(negedge ref_clk);
      evs = 6'h00;
    end
  endtask
  task t_defaults;
    begin
      rchk(8'h58, 8'h40);
      rchk(8'h41, 8'hFF);
      rchk(8'h5D, 8'h00);
      rchk(8'h5E, 8'h00);
      rchk(8'h5C, 8'h00);
    end
  endtask
  // Every data type lands on some line in one of the two fields
  task t_lines;
    int k;
    begin
      for (k = 0; k < 23; k++)
        wr(8'h41 + k, {k[3:0], ~k[3:0]});
      for (k = 0; k < 23; k++) begin
        rchk(8'h41 + k, {k[3:0], ~k[3:0]});
        line_count = k + 2;
        #1 chk(line_data_type, k[3:0]);
        field_raw = 1'b1;
        #1 chk(line_data_type, {~k[3:0]});
        field_raw = 1'b0;
        wr(8'h58, 8'h5A + k);
      end
      line_count = 9'd25;
      #1 chk(line_data_type, 4'hF);
    end
  endtask
  task t_offsets;
    begin
      wr(8'h59, 8'h47);
      wr(8'h5A, 8'h03);
      wr(8'h5B, 8'h13);
      chk(slice_hpos, 11'h347);
      chk(slice_vpos, 9'h103);
      wr(8'h5A, 8'h06);
      wr(8'h5B, 8'hFF);
      rchk(8'h5B, 8'hD7);
      chk(slice_vpos, 9'h106);
      rchk(8'h61, 8'h21);
      rchk(8'h62, 8'h9F);
      slice_byte_in = 8'h00;
      @(negedge ref_clk) chk(slice_byte_out, 8'h03);
      slice_byte_in = 8'hFF;
      @(negedge ref_clk) chk(slice_byte_out, 8'hFC);
      wr(8'h5B, 8'h00);
      @(negedge ref_clk) chk(slice_byte_out, 8'hFF);
    end
  endtask
  task t_ids;
    begin
      wr(8'h5D, 8'h3E);
      chk(frame_style, 2'h1);
      wr(8'h5D, 8'hFF);
      chk({frame_style, anc_data_id}, {2'h2, 6'h3F});
      decoder_even_field = 1'b1;
      #1 chk({slicer_field_out, slicer_vblank_out}, 2'b10);
      {decoder_even_field, decoder_vert_blank} = 2'b01;
      #1 chk({slicer_field_out, slicer_vblank_out}, 2'b01);
      wr(8'h5D, 8'h00);
      chk(frame_style, 2'h0);
      wr(8'h5E, 8'hFF);
      rchk(8'h5E, 8'h3F);
      chk(anc_secondary_id, 6'h3F);
    end
  endtask
  task t_status;
    begin
      pulse(6'h12);
      pulse(6'h21);
      rchk(8'h60, 8'h4C);
      wr(8'h60, 8'hFF);
      rchk(8'h60, 8'h4C);
      pulse(6'h0C);
      pulse(6'h20);
      rchk(8'h60, 8'h30);
    end
  endtask
  initial begin
    repeat (5) @(negedge ref_clk);
    rst = 1'b0;
    t_defaults;
    t_lines;
    t_offsets;
    t_ids;
    t_status;
    complete_run;
  end
endmodule // vsc_slicer_regs_tb
